//--- core/autoload_map.vh
// constants for the configuration auto-loader: eeprom layout, sram windows,
// phy setup codes and serial timing. definitions only.
`ifndef AUTOLOAD_MAP_VH
`define AUTOLOAD_MAP_VH

// ==========================================================
// eeprom layout
`define SIG_WORD        16'h5aa5
`define EE_ADDR_SIG     6'h00
`define EE_ADDR_PHY     6'h02
`define EE_ADDR_MAC0    6'h03
`define EE_ADDR_MAC2    6'h05
`define PHY_FIELD_HI    10
`define PHY_FIELD_LO    8

// ==========================================================
// sram windows (word addresses)
`define WIN0_BASE       16'h0000
`define WIN0_LAST       16'h001f
`define WIN1_BASE       16'h0400
`define WIN1_LAST       16'h040f
`define WIN0_WORDS      6'h20
`define WIN1_WORDS      6'h10

// ==========================================================
// phy setup codes
`define PHY_AN_ALL      3'h0
`define PHY_AN_100      3'h1
`define PHY_AN_10       3'h2
`define PHY_RSVD        3'h3
`define PHY_F100_FDX    3'h4
`define PHY_F100_HDX    3'h5
`define PHY_F10_FDX     3'h6
`define PHY_F10_HDX     3'h7
`define PHY_RESET_VAL   3'h0

// ==========================================================
// serial timing
`define MCLK_HZ         50000000
`define EE_CLK_HZ       1000000
`define EE_HALF_CYC     ((`MCLK_HZ / `EE_CLK_HZ) / 2)
`define EE_READ_OP      3'h6

`endif

//--- core/ee_word_reader.v
// serial eeprom word reader: 3-wire microwire style read of one 16-bit word.
// assumes the eeprom samples on rising clock, drives data after it, 6-bit address.
`timescale 1ns/1ps
`include "autoload_map.vh"

module ee_word_reader #(
    parameter HALF = `EE_HALF_CYC
) (
    // clock and reset
    input  wire        mclk,
    input  wire        rst_n,
    input  wire        ce,
    // request
    input  wire        start,
    input  wire [5:0]  addr,
    output wire        busy,
    output reg  [15:0] rdata_q,
    output reg         done_q,
    // pins
    output reg         ee_cs_q,
    output reg         ee_clk_q,
    output reg         ee_do_q,
    input  wire        ee_di
);

// ==========================================================
// shift sequence: 1 start + 2 op + 6 addr + 1 dummy + 16 data = 26 bits
reg [7:0]  div_q;
reg [5:0]  bit_q;
reg [8:0]  cmd_q;
reg        run_q;

assign busy = run_q;

// one bit per two half periods; data sampled on rising edge of ee_clk
always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
        div_q    <= 8'h00;
        bit_q    <= 6'h00;
        cmd_q    <= 9'h000;
        run_q    <= 1'b0;
        ee_cs_q  <= 1'b0;
        ee_clk_q <= 1'b0;
        ee_do_q  <= 1'b0;
        rdata_q  <= 16'h0000;
        done_q   <= 1'b0;
    end else if (ce) begin
        done_q <= 1'b0;
        if (!run_q) begin
            if (start) begin
                run_q   <= 1'b1;
                ee_cs_q <= 1'b1;
                ee_do_q <= 1'b1;             // start bit, top bit of the read op
                cmd_q   <= {`EE_READ_OP, addr} << 1;  // op tail, address, then a zero
                bit_q   <= 6'h00;
                div_q   <= 8'h00;
            end
        end else if (div_q == HALF[7:0] - 8'h01) begin
            div_q    <= 8'h00;
            ee_clk_q <= ~ee_clk_q;
            if (ee_clk_q) begin
                // falling edge: next bit out
                if (bit_q == 6'h19) begin
                    run_q   <= 1'b0;
                    ee_cs_q <= 1'b0;
                    done_q  <= 1'b1;
                end else begin
                    bit_q <= bit_q + 6'h01;
                    if (bit_q < 6'h09) begin
                        ee_do_q <= cmd_q[8];
                        cmd_q   <= {cmd_q[7:0], 1'b0};
                    end else begin
                        ee_do_q <= 1'b0;
                    end
                end
            end else if (bit_q >= 6'h0a) begin
                rdata_q <= {rdata_q[14:0], ee_di};  // msb first
            end
        end else begin
            div_q <= div_q + 8'h01;
        end
    end
end

endmodule // ee_word_reader

//--- core/eeprom_config_autoloader.v
// eeprom configuration auto-loader: after reset reads the serial eeprom,
// checks the signature, fills two sram windows and sets up the phy.
// assumes an sram write port that takes one word per cycle, no stall.
`timescale 1ns/1ps
`include "autoload_map.vh"

module eeprom_config_autoloader #(
    parameter HALF = `EE_HALF_CYC
) (
    // clock and reset
    input  wire        mclk,
    input  wire        resetn,
    input  wire        ce,
    // eeprom pins (data pin split in/out/enable)
    output wire        ee_cs,
    output wire        ee_clk,
    output wire        ee_dio_o,
    output wire        ee_dio_oe,
    input  wire        ee_dio_i,
    // host eeprom path, usable only after load
    input  wire        host_ee_cs,
    input  wire        host_ee_clk,
    input  wire        host_ee_do,
    input  wire        host_ee_oe,
    output wire        host_ee_di,
    // sram write port
    output reg         sram_we_q,
    output reg  [15:0] sram_addr_q,
    output reg  [15:0] sram_wdata_q,
    // phy setup
    output reg  [2:0]  phy_setup_field,
    output reg         phy_an_en_q,
    output reg         phy_100_q,
    output reg         phy_10_q,
    output reg         phy_fdx_q,
    // status
    output reg         load_done_q,
    output reg         sig_ok_q,
    output reg  [47:0] mac_q
);

// ==========================================================
// reset release through two flops
reg rs1_q, rs2_q;
always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
        rs1_q <= 1'b0;
        rs2_q <= 1'b0;
    end else begin
        rs1_q <= 1'b1;
        rs2_q <= rs1_q;
    end
end
wire rst_n = rs2_q;

// ==========================================================
// states, one-hot
localparam S_IDLE = 5'b00001;
localparam S_SIG  = 5'b00010;
localparam S_COPY = 5'b00100;
localparam S_WAIT = 5'b01000;
localparam S_DONE = 5'b10000;

reg  [4:0]  st_q;
reg  [5:0]  idx_q;
reg         start_q;
wire        rd_busy;
wire        rd_done;
wire [15:0] rd_data;
wire        l_cs, l_clk, l_do;

ee_word_reader #(.HALF(HALF)) u_rd (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .ce      (ce),
    .start   (start_q),
    .addr    (idx_q),
    .busy    (rd_busy),
    .rdata_q (rd_data),
    .done_q  (rd_done),
    .ee_cs_q (l_cs),
    .ee_clk_q(l_clk),
    .ee_do_q (l_do),
    .ee_di   (ee_dio_i)
);

// ==========================================================
// map eeprom index to sram word: words 0..1f to window 0, 0..f also to 1
function [15:0] win1_addr;
    input [5:0] i;
    begin
        win1_addr = `WIN1_BASE + {12'h000, i[3:0]};
    end
endfunction

// decode phy field into mode bits
function [3:0] phy_mode;                 // {an, 100, 10, fdx}
    input [2:0] f;
    begin
        case (f)
            `PHY_AN_ALL:   phy_mode = 4'hf;
            `PHY_AN_100:   phy_mode = 4'hd;      // both duplex abilities kept
            `PHY_AN_10:    phy_mode = 4'hb;      // both duplex abilities kept
            `PHY_RSVD:     phy_mode = 4'hf;      // reserved behaves as default
            `PHY_F100_FDX: phy_mode = 4'h5;
            `PHY_F100_HDX: phy_mode = 4'h4;
            `PHY_F10_FDX:  phy_mode = 4'h3;
            `PHY_F10_HDX:  phy_mode = 4'h2;
            default:       phy_mode = 4'hf;
        endcase
    end
endfunction

reg        dual_q;    // window 1 write pending, issued before the window 0 write
reg [15:0] word_q;

// ==========================================================
// sequencer
always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
        st_q            <= S_IDLE;
        idx_q           <= 6'h00;
        start_q         <= 1'b0;
        sram_we_q       <= 1'b0;
        sram_addr_q     <= 16'h0000;
        sram_wdata_q    <= 16'h0000;
        phy_setup_field <= `PHY_RESET_VAL;
        {phy_an_en_q, phy_100_q, phy_10_q, phy_fdx_q} <= 4'hf;
        load_done_q     <= 1'b0;
        sig_ok_q        <= 1'b0;
        mac_q           <= 48'h0;
        dual_q          <= 1'b0;
        word_q          <= 16'h0000;
    end else if (ce) begin
        start_q   <= 1'b0;
        sram_we_q <= 1'b0;
        case (st_q)
            S_IDLE: begin
                idx_q   <= `EE_ADDR_SIG;
                start_q <= 1'b1;
                st_q    <= S_SIG;
            end
            S_SIG: if (rd_done) begin
                if (rd_data == `SIG_WORD) begin
                    sig_ok_q <= 1'b1;
                    word_q   <= rd_data;
                    dual_q   <= 1'b1;
                    st_q     <= S_WAIT;
                end else begin
                    st_q     <= S_DONE;          // phy keeps default
                end
            end
            S_COPY: if (rd_done) begin
                word_q <= rd_data;
                dual_q <= (idx_q < `WIN1_WORDS);
                if (idx_q == `EE_ADDR_PHY) begin
                    phy_setup_field <= rd_data[`PHY_FIELD_HI:`PHY_FIELD_LO];
                    {phy_an_en_q, phy_100_q, phy_10_q, phy_fdx_q}
                        <= phy_mode(rd_data[`PHY_FIELD_HI:`PHY_FIELD_LO]);
                end
                if (idx_q >= `EE_ADDR_MAC0 && idx_q <= `EE_ADDR_MAC2)
                    mac_q <= {rd_data, mac_q[47:16]};  // low word first
                st_q <= S_WAIT;
            end
            S_WAIT: begin
                // only sram is written; station address is left to host
                sram_we_q    <= 1'b1;
                sram_wdata_q <= word_q;
                if (dual_q) begin
                    sram_addr_q <= win1_addr(idx_q);
                    dual_q      <= 1'b0;
                end else begin
                    sram_addr_q <= `WIN0_BASE + {10'h000, idx_q};
                    if (idx_q == `WIN0_WORDS - 6'h01) begin
                        st_q <= S_DONE;
                    end else begin
                        idx_q   <= idx_q + 6'h01;
                        start_q <= 1'b1;
                        st_q    <= S_COPY;
                    end
                end
            end
            S_DONE: load_done_q <= 1'b1;
            default: st_q <= S_IDLE;
        endcase
    end
end

// ==========================================================
// data pin hand-over: count eeprom clock rises in a frame; after the
// ninth (last address bit) the loader lets go, so the dummy bit and the
// data come back on a pin that only the eeprom drives
reg [3:0] hdr_q;
reg       lclk_q;
always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
        hdr_q  <= 4'h0;
        lclk_q <= 1'b0;                  // idle level of the eeprom clock, no false rise
    end else if (ce) begin
        lclk_q <= l_clk;
        if (!rd_busy) begin
            hdr_q <= 4'h0;
        end else if (l_clk && !lclk_q && hdr_q != 4'h9) begin
            hdr_q <= hdr_q + 4'h1;
        end
    end
end
wire hdr_phase = (hdr_q != 4'h9);

// ==========================================================
// pin mux: host reaches the eeprom only once loading is over
assign ee_cs      = load_done_q ? host_ee_cs  : l_cs;
assign ee_clk     = load_done_q ? host_ee_clk : l_clk;
assign ee_dio_o   = load_done_q ? host_ee_do  : l_do;
assign ee_dio_oe  = load_done_q ? host_ee_oe  : (l_cs & hdr_phase);
assign host_ee_di = load_done_q ? ee_dio_i    : 1'b0;

endmodule // eeprom_config_autoloader

//--- verif/autoload_assertions.sv
// checker for the auto-loader: load outcome, sram windows, phy modes, host path.
// assumes it is bound to eeprom_config_autoloader and sees only its ports.
`timescale 1ns/1ps
module autoload_chk (
    // clock and reset
    input wire        mclk,
    input wire        resetn,
    // pins and host path
    input wire        ee_cs,
    input wire        ee_clk,
    input wire        host_ee_cs,
    input wire        host_ee_clk,
    input wire        host_ee_di,
    // sram, phy, status
    input wire        sram_we_q,
    input wire [15:0] sram_addr_q,
    input wire [2:0]  phy_setup_field,
    input wire        phy_an_en_q,
    input wire        phy_100_q,
    input wire        phy_10_q,
    input wire        phy_fdx_q,
    input wire        load_done_q,
    input wire        sig_ok_q
);
    // ==========================================================
    // properties
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    // a read frame keeps the part selected for many cycles
    sequence sel_frame;
        ee_cs [*8];
    endsequence
    sequence host_steady;
        load_done_q && $past(load_done_q) && $stable(host_ee_cs) && $stable(host_ee_clk);
    endsequence
    frame_hold_a: assert property ($rose(ee_cs) && !load_done_q |-> sel_frame)
        else $error("eeprom select dropped early");
    no_write_bad_a: assert property (load_done_q && !sig_ok_q |-> !sram_we_q)
        else $error("sram written without signature");
    write_window_a: assert property (sram_we_q |-> sram_addr_q <= 16'h001f ||
        (sram_addr_q >= 16'h0400 && sram_addr_q <= 16'h040f))
        else $error("sram write outside windows");
    done_sticky_a: assert property (load_done_q |=> load_done_q)
        else $error("load done dropped");
    host_gate_a: assert property (!load_done_q |-> !host_ee_di)
        else $error("host data seen before load done");
    host_pass_a: assert property (host_steady |-> ee_cs == host_ee_cs && ee_clk == host_ee_clk)
        else $error("host lines not passed through");
    phy_default_a: assert property (load_done_q && !sig_ok_q |-> phy_setup_field == 3'h0 &&
        phy_an_en_q && phy_100_q && phy_10_q && phy_fdx_q)
        else $error("phy not left at default");
    forced_mode_a: assert property (load_done_q && phy_setup_field[2] |-> !phy_an_en_q &&
        phy_100_q == !phy_setup_field[1] && phy_10_q == phy_setup_field[1] &&
        phy_fdx_q == !phy_setup_field[0])
        else $error("forced phy mode wrong");
    autoneg_mode_a: assert property (load_done_q && !phy_setup_field[2] |-> phy_an_en_q &&
        phy_fdx_q && phy_100_q == (phy_setup_field[1:0] != 2'h2) &&
        phy_10_q == (phy_setup_field[1:0] != 2'h1))
        else $error("autoneg phy mode wrong");
endmodule // autoload_chk

bind eeprom_config_autoloader autoload_chk u_chk (.mclk(mclk), .resetn(resetn), .ee_cs(ee_cs),
    .ee_clk(ee_clk), .host_ee_cs(host_ee_cs), .host_ee_clk(host_ee_clk),
    .host_ee_di(host_ee_di), .sram_we_q(sram_we_q), .sram_addr_q(sram_addr_q),
    .phy_setup_field(phy_setup_field), .phy_an_en_q(phy_an_en_q), .phy_100_q(phy_100_q),
    .phy_10_q(phy_10_q), .phy_fdx_q(phy_fdx_q), .load_done_q(load_done_q),
    .sig_ok_q(sig_ok_q));

//--- verif/ee_model.sv
// serial eeprom model: 3-wire read, start bit, opcode, 6-bit address, dummy, 16 bits.
// assumes the bench resolves the shared data pin with a pull-up when nobody drives.
`timescale 1ns/1ps
module ee_model (
    // pins
    input wire        cs,
    input wire        sclk,
    input wire        din,
    output reg        dout,
    output reg        dout_oe
);
    reg [15:0] mem [0:63];
    reg [5:0]  addr_q;
    integer    k;
    // ==========================================================
    // header shift on rising clock; deselect restarts the frame
    always @(posedge sclk or negedge cs) begin
        if (!cs) begin
            k <= 0;
        end else begin
            k <= k + 1;
            if (k >= 3 && k <= 8) addr_q <= {addr_q[4:0], din};
        end
    end
    // dummy zero then data msb first, driven on falling clock
    always @(negedge sclk or negedge cs) begin
        if (!cs) begin
            dout_oe <= 1'b0;
        end else if (k >= 9 && k <= 25) begin
            dout_oe <= 1'b1;
            dout    <= (k == 9) ? 1'b0 : mem[addr_q][25 - k];
        end else begin
            dout_oe <= 1'b0;
        end
    end
endmodule // ee_model

//--- verif/tb_top.sv
// bench for the auto-loader: every phy code, bad signature, host pass-through.
// assumes the design is built with a short serial bit period.
`timescale 1ns/1ps
module tb_top;
    reg         mclk = 0, resetn = 0, ce = 1;
    reg         host_ee_cs = 0, host_ee_clk = 0, host_ee_do = 0, host_ee_oe = 0;
    wire        ee_cs, ee_clk, ee_dio_o, ee_dio_oe, host_ee_di, m_do, m_oe;
    wire        sram_we_q, phy_an_en_q, phy_100_q, phy_10_q, phy_fdx_q, load_done_q, sig_ok_q;
    wire [15:0] sram_addr_q, sram_wdata_q;
    wire [2:0]  phy_setup_field;
    wire [47:0] mac_q;
    // pull-up wins when nobody drives; the eeprom beats the loader
    wire        ee_pin = m_oe ? m_do : (ee_dio_oe ? ee_dio_o : 1'b1);
    integer     error_cnt = 0, checks = 0, wr_cnt = 0, n, t, i, p;
    reg [2:0]   code;
    reg [15:0]  sig;
    always #10 mclk = ~mclk;
    eeprom_config_autoloader #(.HALF(2)) dut (.mclk(mclk), .resetn(resetn), .ce(ce),
        .ee_cs(ee_cs), .ee_clk(ee_clk), .ee_dio_o(ee_dio_o), .ee_dio_oe(ee_dio_oe),
        .ee_dio_i(ee_pin), .host_ee_cs(host_ee_cs), .host_ee_clk(host_ee_clk),
        .host_ee_do(host_ee_do), .host_ee_oe(host_ee_oe), .host_ee_di(host_ee_di),
        .sram_we_q(sram_we_q), .sram_addr_q(sram_addr_q), .sram_wdata_q(sram_wdata_q),
        .phy_setup_field(phy_setup_field), .phy_an_en_q(phy_an_en_q), .phy_100_q(phy_100_q),
        .phy_10_q(phy_10_q), .phy_fdx_q(phy_fdx_q), .load_done_q(load_done_q),
        .sig_ok_q(sig_ok_q), .mac_q(mac_q));
    ee_model ee (.cs(ee_cs), .sclk(ee_clk), .din(ee_pin), .dout(m_do), .dout_oe(m_oe));
    // ==========================================================
    // helpers
    task chk(input string nm, input [63:0] seen, input [63:0] exp);
        checks = checks + 1;
        if (seen !== exp) begin
            error_cnt = error_cnt + 1;
            $display("[FAIL] %0s expected %h seen %h", nm, exp, seen);
        end
    endtask
    function [15:0] ew(input integer a);
        ew = (a == 0) ? sig : (a == 2) ? {5'h00, code, 8'h00} : (a == 3) ? 16'h3210 :
             (a == 4) ? 16'h7654 : (a == 5) ? 16'hba98 : {2'h2, a[5:0], 8'h5c};
    endfunction
    // every sram write must carry the matching eeprom word
    always @(posedge mclk) begin
        if (sram_we_q === 1'b1) begin
            wr_cnt = wr_cnt + 1;
            n = (sram_addr_q >= 16'h0400) ? sram_addr_q - 16'h0400 : sram_addr_q;
            chk("sram_data", sram_wdata_q, ew(n));
        end
    end
    // host lines held busy during the load to provoke the gate
    task run_load(input [2:0] c, input [15:0] s);
        code = c;
        sig  = s;
        for (i = 0; i < 64; i = i + 1) ee.mem[i] = ew(i);
        @(posedge mclk) #1;
        resetn = 0;
        {host_ee_cs, host_ee_clk, host_ee_do, host_ee_oe} = 4'hf;
        repeat (4) @(posedge mclk);
        #1 resetn = 1;
        wr_cnt = 0;
        t = 0;
        while (load_done_q !== 1'b1 && t < 20000) begin
            @(posedge mclk);
            t = t + 1;
        end
        if (t >= 20000) begin
            error_cnt = error_cnt + 1;   // load never finished
            conclude;
        end
        repeat (4) @(posedge mclk);
        #1;
    endtask
    // ==========================================================
    // scenarios
    task t_good(input [2:0] c);
        run_load(c, 16'h5aa5);
        chk("writes", wr_cnt, 48);
        chk("sig_ok", sig_ok_q, 1'b1);
        chk("mac", mac_q, 48'hba9876543210); // host takes the address from here
        chk("phy_field", phy_setup_field, c);
        chk("phy_mode", {phy_an_en_q, phy_100_q, phy_10_q, phy_fdx_q},
            (32'h2345fbdf >> (4 * c)) & 32'hf);
    endtask
    // one bit off the signature, forced code stored behind it
    task t_bad_sig;
        run_load(3'h4, 16'h5aa4);
        chk("done", load_done_q, 1'b1);
        chk("writes", wr_cnt, 0);
        chk("sig_ok", sig_ok_q, 1'b0);
        chk("phy_field", phy_setup_field, 3'h0);
        chk("phy_mode", {phy_an_en_q, phy_100_q, phy_10_q, phy_fdx_q}, 4'hf);
    endtask
    task t_host;
        {host_ee_cs, host_ee_clk, host_ee_do, host_ee_oe} = 4'h8;
        repeat (3) @(posedge mclk);
        #1 chk("host_cs", ee_cs, 1'b1);
        chk("host_di_pullup", host_ee_di, 1'b1);
        host_ee_oe = 1;
        repeat (3) @(posedge mclk);
        #1 chk("host_oe", ee_dio_oe, 1'b1);
        chk("host_di_low", host_ee_di, 1'b0);
    endtask
    task conclude;
        if (error_cnt == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // ==========================================================
    // main sequence and watchdog
    initial begin
        for (p = 0; p < 8; p = p + 1) t_good(p[2:0]);
        t_bad_sig;
        t_host;
        conclude;
    end
    initial begin
        #(20 * 60000);
        error_cnt = error_cnt + 1;
        conclude;
    end
endmodule // tb_top
